// File: wcs_sequencer.sv
// weld schedule sequencer with avalon-mm register slave and schedule store
// assumes switch inputs and cycle tick are synchronous to clk_sys
//
// Added by the designer: register access over Avalon-MM and the register offsets.
`timescale 1ns/100ps
module wcs_sequencer #(
	parameter int BACKSTEP_LONG_CYCLES = wcs_pkg::BACKSTEP_LONG_CYC
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// avalon-mm slave
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// machine inputs
	input wire logic cycleTick,
	input wire logic initiate,
	input wire logic pressureClosed,
	input wire logic back_step_input,
	input wire logic first_jump_initiation,
	input wire logic second_jump_initiation,
	input wire logic schedule_select_bit_a,
	input wire logic schedule_select_bit_b,
	// machine outputs
	output logic [2:0] valveOn,
	output logic weldOn,
	output logic [7:0] weldPercent,
	output logic [5:0] displaySched,
	output logic schedFlash,
	output logic squeezeFlash,
	output logic holdBlink,
	output logic errorFlash,
	output wcs_pkg::wcs_state_t seqState
);
	import wcs_pkg::*;

	wcs_state_t state_q, state_d;
	logic fresh_q, fresh_d;
	logic [7:0] cnt_q, cnt_d, pulse_q, pulse_d;
	logic [5:0] cur_q, cur_d, origin_q, origin_d, disp_q, disp_d, seriesStart_q, seriesStart_d;
	logic seriesActive_q, seriesActive_d;
	logic initS_q, pressS_q, backS_q, jumpAS_q, jumpBS_q;
	logic [25:0] backCnt_q;
	logic [31:0] ctrl_q, index_q, readdata_q;
	logic ack_q;
	logic [2:0] valve_q;
	logic weldOn_q, sqzFlash_q, holdBlink_q, err_q;
	logic [7:0] pct_q;
	logic [31:0] timesMem [SCHED_COUNT];
	logic [31:0] modesMem [SCHED_COUNT];

	// bus decode and handshake: one wait state, then the access completes
	wire busReq = avs_read | avs_write;
	wire busDone = busReq & ack_q;
	wire wrCtrl = avs_write & busDone & (avs_address == ADDR_CTRL);
	wire wrIndex = avs_write & busDone & (avs_address == ADDR_INDEX);
	wire wrTimes = avs_write & busDone & (avs_address == ADDR_TIMES);
	wire wrModes = avs_write & busDone & (avs_address == ADDR_MODES);
	wire idxOk = index_q[5:0] <= SCHED_LAST;
	wire [5:0] idx = idxOk ? index_q[5:0] : 6'h00;
	wire [31:0] beMask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
		{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	assign avs_waitrequest = busReq & ~ack_q;
	assign avs_readdata = readdata_q;

	// control fields and schedule selection
	wire extSelect = ctrl_q[CTRL_EXT_BIT];
	wire [5:0] panelSched = ctrl_q[CTRL_PANEL_LSB +: 6];
	wire [5:0] selSched = extSelect ? {4'h0, schedule_select_bit_b, schedule_select_bit_a} : panelSched;

	// fields of the running schedule
	wire [31:0] curTimes = timesMem[cur_q];
	wire [31:0] curModes = modesMem[cur_q];
	wire [7:0] sqzLen = curTimes[TM_SQZ_LSB +: 8];
	wire [7:0] weldLen = curTimes[TM_WELD_LSB +: 8];
	wire [7:0] holdLen = curTimes[TM_HOLD_LSB +: 8];
	wire [7:0] offLen = curTimes[TM_OFF_LSB +: 8];
	wire [7:0] impCount = curModes[MD_IMP_LSB +: 8];
	wire [7:0] coolLen = curModes[MD_COOL_LSB +: 8];
	wire [7:0] pctField = curModes[MD_PCT_LSB +: 8];
	wire [2:0] valveMask = curModes[MD_VALVE_LSB +: 3];
	wire [2:0] cycMode = curModes[MD_CYC_LSB +: 3];

	// successor schedule and previous schedule with wrap
	wire [5:0] curNext = (cur_q == SCHED_LAST) ? 6'h00 : cur_q + 6'h01;
	wire [5:0] dispPrev = (disp_q == 6'h00) ? SCHED_LAST : disp_q - 6'h01;

	// sampled switch events; initiation and back-step edges taken only on the line-cycle tick
	wire initRise = cycleTick & initiate & ~initS_q;
	wire backRise = cycleTick & back_step_input & ~backS_q;
	wire cntZero = cnt_q == 8'h00;
	wire cntStep = cycleTick & ~cntZero;
	wire holdDone = (state_q == ST_HOLD) & ~fresh_q & cntZero;
	wire inIdleSeries = (state_q == ST_IDLE) & seriesActive_q;
	wire backLong = backCnt_q == 26'(BACKSTEP_LONG_CYCLES);
	wire backJump = backS_q & inIdleSeries & (backCnt_q == 26'(BACKSTEP_LONG_CYCLES - 1));
	wire [5:0] endDisp = seriesActive_q ? seriesStart_q : selSched;

	// interval length of the state just entered
	logic [7:0] intervalLen;
	always_comb begin
		unique case (state_q)
			ST_SQUEEZE: intervalLen = sqzLen;
			ST_WELD: intervalLen = weldLen;
			ST_COOL: intervalLen = coolLen;
			ST_HOLD: intervalLen = holdLen;
			ST_OFF: intervalLen = offLen;
			default: intervalLen = 8'h00;
		endcase
	end

	// sequence state machine
	always_comb begin
		state_d = state_q;
		fresh_d = 1'b0;
		cnt_d = cnt_q;
		pulse_d = pulse_q;
		cur_d = cur_q;
		origin_d = origin_q;
		disp_d = disp_q;
		seriesStart_d = seriesStart_q;
		seriesActive_d = seriesActive_q;
		if (fresh_q) begin
			cnt_d = intervalLen;
			if (state_q == ST_SQUEEZE) begin
				pulse_d = impCount;
			end
		end else begin
			unique case (state_q)
				ST_IDLE: begin
					if (!seriesActive_q) begin
						disp_d = selSched;
					end else if (backJump) begin
						disp_d = seriesStart_q;
					end else if (backRise && disp_q != seriesStart_q) begin
						disp_d = dispPrev;
					end
					if (initRise) begin
						cur_d = disp_q;
						origin_d = disp_q;
						state_d = ST_SQUEEZE;
						fresh_d = 1'b1;
					end
				end
				ST_SQUEEZE: begin
					if (cntZero) begin
						if (pressS_q) begin
							state_d = ST_WELD;
							fresh_d = 1'b1;
						end
					end else if (cntStep) begin
						cnt_d = cnt_q - 8'h01;
					end
				end
				ST_WELD: begin
					if (cntZero) begin
						fresh_d = 1'b1;
						if (pulse_q > 8'h01) begin
							pulse_d = pulse_q - 8'h01;
							state_d = ST_COOL;
						end else begin
							state_d = ST_HOLD;
						end
					end else if (cntStep) begin
						cnt_d = cnt_q - 8'h01;
					end
				end
				ST_COOL: begin
					if (cntZero) begin
						state_d = ST_WELD;
						fresh_d = 1'b1;
					end else if (cntStep) begin
						cnt_d = cnt_q - 8'h01;
					end
				end
				ST_HOLD: begin
					if (cntZero) begin
						unique case (cycMode)
							MODE_REPEAT: begin
								state_d = ST_OFF;
								fresh_d = 1'b1;
							end
							MODE_CHAINED: begin
								cur_d = curNext;
								state_d = ST_SQUEEZE;
								fresh_d = 1'b1;
							end
							MODE_SUCCESSIVE: begin
								state_d = ST_IDLE;
								disp_d = curNext;
								if (!seriesActive_q) begin
									seriesActive_d = 1'b1;
									seriesStart_d = extSelect ? selSched : origin_q;
								end
							end
							MODE_CONDSUCC: state_d = ST_CONDWAIT;
							MODE_WAITHERE: state_d = ST_JUMPWAIT;
							default: begin
								state_d = ST_IDLE;
								disp_d = endDisp;
								seriesActive_d = 1'b0;
							end
						endcase
					end else if (cntStep) begin
						cnt_d = cnt_q - 8'h01;
					end
				end
				ST_OFF: begin
					if (cntZero) begin
						if (initS_q) begin
							cur_d = origin_q;
							state_d = ST_SQUEEZE;
							fresh_d = 1'b1;
						end else begin
							state_d = ST_IDLE;
							disp_d = endDisp;
							seriesActive_d = 1'b0;
						end
					end else if (cntStep) begin
						cnt_d = cnt_q - 8'h01;
					end
				end
				ST_CONDWAIT: begin
					if (initRise) begin
						cur_d = (cur_q != origin_q) ? origin_q : curNext;
						state_d = ST_SQUEEZE;
						fresh_d = 1'b1;
					end
				end
				ST_JUMPWAIT: begin
					if (jumpAS_q || jumpBS_q) begin
						cur_d = jumpAS_q ? SCHED_JUMP_A : SCHED_JUMP_B;
						origin_d = cur_d;
						state_d = ST_SQUEEZE;
						fresh_d = 1'b1;
					end
				end
			endcase
		end
	end

	// sequencer registers
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_IDLE;
			fresh_q <= 1'b0;
			cnt_q <= 8'h00;
			pulse_q <= 8'h00;
			cur_q <= 6'h00;
			origin_q <= 6'h00;
			disp_q <= 6'h00;
			seriesStart_q <= 6'h00;
			seriesActive_q <= 1'b0;
		end else begin
			state_q <= state_d;
			fresh_q <= fresh_d;
			cnt_q <= cnt_d;
			pulse_q <= pulse_d;
			cur_q <= cur_d;
			origin_q <= origin_d;
			disp_q <= disp_d;
			seriesStart_q <= seriesStart_d;
			seriesActive_q <= seriesActive_d;
		end
	end

	// switch samples on the line-cycle tick
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			{initS_q, pressS_q, backS_q, jumpAS_q, jumpBS_q} <= 5'h00;
		end else if (cycleTick) begin
			{initS_q, pressS_q, backS_q} <= {initiate, pressureClosed, back_step_input};
			{jumpAS_q, jumpBS_q} <= {first_jump_initiation, second_jump_initiation};
		end
	end

	// back-step hold timer, saturating at the long-press count
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			backCnt_q <= 26'h0000000;
		end else if (!backS_q || !inIdleSeries) begin
			backCnt_q <= 26'h0000000;
		end else if (!backLong) begin
			backCnt_q <= backCnt_q + 26'h0000001;
		end
	end

	// machine outputs from flip-flops
	wire valvesActive = (state_q != ST_IDLE) & (state_q != ST_OFF);
	wire weldActive = (state_q == ST_WELD) & ~fresh_q & ~cntZero;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			valve_q <= 3'h0;
			weldOn_q <= 1'b0;
			pct_q <= 8'h00;
			sqzFlash_q <= 1'b0;
			holdBlink_q <= 1'b0;
			err_q <= 1'b0;
		end else begin
			valve_q <= valvesActive ? valveMask : 3'h0;
			weldOn_q <= weldActive;
			pct_q <= weldActive ? pctField : 8'h00;
			sqzFlash_q <= (state_q == ST_SQUEEZE) & ~fresh_q & cntZero & ~pressS_q;
			holdBlink_q <= state_q == ST_CONDWAIT;
			err_q <= backS_q & backLong & inIdleSeries;
		end
	end
	assign valveOn = valve_q;
	assign weldOn = weldOn_q;
	assign weldPercent = pct_q;
	assign displaySched = disp_q;
	assign schedFlash = seriesActive_q;
	assign squeezeFlash = sqzFlash_q;
	assign holdBlink = holdBlink_q;
	assign errorFlash = err_q;
	assign seqState = state_q;

	// bus registers and read data
	logic [31:0] rdMux;
	always_comb begin
		unique case (avs_address)
			ADDR_CTRL: rdMux = ctrl_q;
			ADDR_STATUS: rdMux = {6'h00, err_q, seriesActive_q, 2'h0, disp_q, 2'h0, cur_q, 5'h00, state_q};
			ADDR_INDEX: rdMux = index_q;
			ADDR_TIMES: rdMux = timesMem[idx];
			ADDR_MODES: rdMux = modesMem[idx];
			default: rdMux = 32'h0000_0000;
		endcase
	end
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ack_q <= 1'b0;
			readdata_q <= 32'h0000_0000;
			ctrl_q <= CTRL_RESET;
			index_q <= 32'h0000_0000;
		end else begin
			ack_q <= busReq & ~ack_q;
			if (avs_read && !ack_q) begin
				readdata_q <= rdMux;
			end
			if (wrCtrl) begin
				ctrl_q <= (ctrl_q & ~beMask) | (avs_writedata & beMask & 32'h0000_3F01);
			end
			if (wrIndex) begin
				index_q <= (index_q & ~beMask) | (avs_writedata & beMask & 32'h0000_003F);
			end
		end
	end

	// schedule store, one entry per schedule
	genvar gi;
	generate
		for (gi = 0; gi < SCHED_COUNT; gi++) begin : g_sched
			wire hit = idxOk & (index_q[5:0] == 6'(gi));
			always_ff @(posedge clk_sys or negedge rst_n) begin
				if (!rst_n) begin
					timesMem[gi] <= SCHED_RESET;
					modesMem[gi] <= SCHED_RESET;
				end else begin
					if (wrTimes && hit) begin
						timesMem[gi] <= (timesMem[gi] & ~beMask) | (avs_writedata & beMask);
					end
					if (wrModes && hit) begin
						modesMem[gi] <= (modesMem[gi] & ~beMask) | (avs_writedata & beMask & 32'hFFFF_FF77);
					end
				end
			end
		end
	endgenerate

	// checks
	chk_squeeze_press_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(state_q == ST_SQUEEZE && !fresh_q && cntZero && !pressS_q) |=> (state_q == ST_SQUEEZE && squeezeFlash))
		else $error("weld started with pressure switch open");
	chk_weld_current_level: assert property (@(posedge clk_sys) disable iff (!rst_n)
		weldActive |=> (weldOn && weldPercent == $past(pctField)))
		else $error("weld current missing or wrong level");
	chk_weld_no_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(state_q != ST_WELD) |=> !weldOn)
		else $error("current outside weld interval");
	chk_pulse_to_cool: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(state_q == ST_WELD && !fresh_q && cntZero && pulse_q > 8'h01) |=> state_q == ST_COOL && fresh_q)
		else $error("pulsation skipped cool");
	chk_hold_valves_on: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(state_q == ST_HOLD && !fresh_q) |=> (valveOn == $past(valveMask) && !weldOn))
		else $error("hold lost valves or carried current");
	chk_repeat_restart: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(state_q == ST_OFF && !fresh_q && cntZero && initS_q) |=> (state_q == ST_SQUEEZE && cur_q == origin_q))
		else $error("repeat did not restart");
	chk_chain_next: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(holdDone && cycMode == MODE_CHAINED) |=> (state_q == ST_SQUEEZE && cur_q == $past(curNext)))
		else $error("chain did not advance");
	chk_nonrepeat_end: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(holdDone && cycMode == MODE_NONREPEAT) |=> (state_q == ST_IDLE && displaySched == $past(endDisp)) ##1 valveOn == 3'h0)
		else $error("non-repeat end wrong");
	chk_successive_step: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(holdDone && cycMode == MODE_SUCCESSIVE) |=> (state_q == ST_IDLE && schedFlash && displaySched == $past(curNext)))
		else $error("successive did not advance");
	chk_condwait_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(state_q == ST_CONDWAIT && !initRise) |=> (state_q == ST_CONDWAIT && holdBlink))
		else $error("conditional wait left without initiation");
endmodule

// File: wcs_pkg.sv
// constants, register map and state type of the weld cycle sequencer
// assumes a 25 MHz system clock and a one-cycle line-cycle tick input
// What this block does
// - hold off weld and flash squeeze while pressure switch stays open
// - drive programmed percent current for exactly the programmed weld cycles
// - alternate weld and cool until impulses elapse, then go to hold
// - hold keeps valves on without current; non-repeat drops valves after hold
// - repeat mode restarts at squeeze when initiation is still closed after off
// - per-schedule cycle mode code 00..05 selects what follows hold
// - chained mode runs the next schedule with its own parameters
// - chain ending in non-repeat returns display to the initiated schedule
// - repeat or conditional successive in a chain restarts from initiated schedule
// - successive in a chain ends, selects last plus one, awaits initiation
// - wait-here pauses until one of the two jump initiations closes
// - zero hold, off and squeeze give back-to-back weld intervals
// - end of chain takes display from external select bits or panel entry
// - successive runs as non-repeat then advances selection and flashes it
// - finished successive series reselects the schedule it started from
// - brief back-step closure selects previous schedule, not below series start
// - back-step held 1.5 s jumps to series start; held longer flags error 06
// - conditional successive keeps valves after hold, blinks, waits reinitiation
// - fifty schedules, any may start a chain, successor is N plus one, schedule 0 after 49
// - valve code bits 0..2 drive valves 1..3
package wcs_pkg;
	localparam int SCHED_COUNT = 50;
	localparam logic [5:0] SCHED_LAST = 6'h31;
	localparam logic [5:0] SCHED_JUMP_A = 6'h0A;
	localparam logic [5:0] SCHED_JUMP_B = 6'h14;
	localparam logic [5:0] ADDR_CTRL = 6'h00;
	localparam logic [5:0] ADDR_STATUS = 6'h04;
	localparam logic [5:0] ADDR_INDEX = 6'h08;
	localparam logic [5:0] ADDR_TIMES = 6'h0C;
	localparam logic [5:0] ADDR_MODES = 6'h10;
	localparam int CTRL_EXT_BIT = 0;
	localparam int CTRL_PANEL_LSB = 8;
	localparam int ST_CUR_LSB = 8;
	localparam int ST_DISP_LSB = 16;
	localparam int ST_SERIES_BIT = 24;
	localparam int ST_ERR_BIT = 25;
	localparam int TM_SQZ_LSB = 24;
	localparam int TM_WELD_LSB = 16;
	localparam int TM_HOLD_LSB = 8;
	localparam int TM_OFF_LSB = 0;
	localparam int MD_IMP_LSB = 24;
	localparam int MD_COOL_LSB = 16;
	localparam int MD_PCT_LSB = 8;
	localparam int MD_VALVE_LSB = 4;
	localparam int MD_CYC_LSB = 0;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] SCHED_RESET = 32'h0000_0000;
	localparam logic [2:0] MODE_NONREPEAT = 3'h0;
	localparam logic [2:0] MODE_REPEAT = 3'h1;
	localparam logic [2:0] MODE_CHAINED = 3'h2;
	localparam logic [2:0] MODE_SUCCESSIVE = 3'h3;
	localparam logic [2:0] MODE_CONDSUCC = 3'h4;
	localparam logic [2:0] MODE_WAITHERE = 3'h5;
	localparam int CLK_HZ = 25_000_000;
	localparam int BACKSTEP_LONG_MS = 1500;
	localparam int BACKSTEP_LONG_CYC = (CLK_HZ / 1000) * BACKSTEP_LONG_MS;
	typedef enum logic [2:0] {
		ST_IDLE, ST_SQUEEZE, ST_WELD, ST_COOL, ST_HOLD, ST_OFF, ST_CONDWAIT, ST_JUMPWAIT
	} wcs_state_t;
endpackage

// File: wcs_machine_model.sv
// machine side model: line-cycle tick source and pressure switch
// assumes valve drives from the sequencer and one system clock
`timescale 1ns/100ps
module wcs_machine_model #(
	parameter int TICK_DIV = 4
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// sequencer side
	input wire logic [2:0] valveOn,
	input wire logic [7:0] pressDelay,
	output logic cycleTick,
	output logic pressureClosed
);
	logic [7:0] divCnt_q;
	logic [7:0] pressCnt_q;
	// one-clock tick every TICK_DIV clocks
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			divCnt_q <= 8'h00;
			cycleTick <= 1'b0;
		end else begin
			cycleTick <= (divCnt_q == 8'(TICK_DIV - 1));
			divCnt_q <= (divCnt_q == 8'(TICK_DIV - 1)) ? 8'h00 : divCnt_q + 8'h01;
		end
	end
	// pressure builds some ticks after a valve opens, drops with the valves
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pressCnt_q <= 8'h00;
			pressureClosed <= 1'b0;
		end else if (valveOn == 3'h0) begin
			pressCnt_q <= 8'h00;
			pressureClosed <= 1'b0;
		end else if (cycleTick) begin
			if (pressCnt_q >= pressDelay) pressureClosed <= 1'b1;
			else pressCnt_q <= pressCnt_q + 8'h01;
		end
	end
endmodule

// File: wcs_sequencer_tb.sv
// self-checking bench for the weld cycle sequencer
// assumes the machine model supplies the tick and the pressure switch
`timescale 1ns/100ps
module wcs_sequencer_tb;
	import wcs_pkg::*;
	localparam int BS_CYC = 50;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic [5:0] avs_address = 6'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic cycleTick;
	logic pressureClosed;
	logic initiate = 1'b0;
	logic backStep = 1'b0;
	logic jumpB = 1'b0;
	logic jumpA = 1'b0;
	logic selA = 1'b0;
	logic selB = 1'b0;
	logic [7:0] pressDelay = 8'h01;
	logic [2:0] valveOn;
	logic weldOn;
	logic [7:0] weldPercent;
	logic [5:0] displaySched;
	logic schedFlash;
	logic squeezeFlash;
	logic holdBlink;
	logic errorFlash;
	wcs_state_t seqState;
	wcs_state_t statePrev;
	logic weldPrev;
	int fails = 0;
	int num_checks = 0;
	int weldTicks = 0;
	int weldRises = 0;
	int sqzStarts = 0;
	int badPress = 0;
	logic [2:0] valvesSeen = 3'h0;
	logic [7:0] pctLast = 8'h00;
	logic sqzSeen = 1'b0;
	logic errSeen = 1'b0;
	logic [31:0] rdata;
	// clock
	always #20 clk_sys = ~clk_sys;
	wcs_sequencer #(.BACKSTEP_LONG_CYCLES(BS_CYC)) i_wcs_sequencer (.clk_sys(clk_sys), .rst_n(rst_n),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(4'hF),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.cycleTick(cycleTick), .initiate(initiate), .pressureClosed(pressureClosed),
		.back_step_input(backStep), .first_jump_initiation(jumpA), .second_jump_initiation(jumpB),
		.schedule_select_bit_a(selA), .schedule_select_bit_b(selB), .valveOn(valveOn), .weldOn(weldOn),
		.weldPercent(weldPercent), .displaySched(displaySched), .schedFlash(schedFlash),
		.squeezeFlash(squeezeFlash), .holdBlink(holdBlink), .errorFlash(errorFlash), .seqState(seqState));
	wcs_machine_model i_wcs_machine_model (.clk_sys(clk_sys), .rst_n(rst_n), .valveOn(valveOn),
		.pressDelay(pressDelay), .cycleTick(cycleTick), .pressureClosed(pressureClosed));
	// scoreboard of what the machine sees
	always @(posedge clk_sys) begin
		weldPrev <= weldOn;
		statePrev <= seqState;
		if (cycleTick && weldOn) weldTicks <= weldTicks + 1;
		if (weldOn && !weldPrev) weldRises <= weldRises + 1;
		if (seqState == ST_SQUEEZE && statePrev != ST_SQUEEZE) sqzStarts <= sqzStarts + 1;
		if (weldOn && !pressureClosed) badPress <= badPress + 1;
		if (weldOn) pctLast <= weldPercent;
		valvesSeen <= valvesSeen | valveOn;
		sqzSeen <= sqzSeen | squeezeFlash;
		errSeen <= errSeen | errorFlash;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict();
		if (fails == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// one avalon cycle, held until waitrequest is seen low at a rising edge
	task automatic bus(input logic rd, input logic [5:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		avs_read <= rd;
		avs_write <= !rd;
		avs_address <= a;
		avs_writedata <= d;
		do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
		rdata = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic prog(input logic [5:0] n, input logic [31:0] t, input logic [31:0] m);
		bus(1'b0, ADDR_INDEX, {26'h0, n});
		bus(1'b0, ADDR_TIMES, t);
		bus(1'b0, ADDR_MODES, m);
	endtask
	task automatic clr();
		@(negedge clk_sys);
		weldTicks = 0;
		weldRises = 0;
		sqzStarts = 0;
		badPress = 0;
		valvesSeen = 3'h0;
		pctLast = 8'h00;
		sqzSeen = 1'b0;
		errSeen = 1'b0;
	endtask
	// initiate, hold through a number of squeeze starts, wait for an end state
	task automatic go(input int holdStarts, input wcs_state_t endSt);
		clr();
		@(posedge clk_sys);
		initiate <= 1'b1;
		do @(negedge clk_sys); while (sqzStarts < holdStarts);
		@(posedge clk_sys);
		initiate <= 1'b0;
		do @(negedge clk_sys); while (seqState !== endSt);
		repeat (12) @(posedge clk_sys);
	endtask
	task automatic step(input int cyc);
		@(posedge clk_sys);
		backStep <= 1'b1;
		repeat (cyc) @(posedge clk_sys);
		backStep <= 1'b0;
		repeat (16) @(posedge clk_sys);
	endtask
	task automatic test_regs();
		bus(1'b1, ADDR_CTRL, 32'h0);
		chk(rdata, CTRL_RESET);
		bus(1'b1, 6'h20, 32'h0);
		chk(rdata, 32'h0);
		bus(1'b0, ADDR_INDEX, 32'h32);
		bus(1'b0, ADDR_TIMES, 32'hFFFF_FFFF);
		bus(1'b0, ADDR_INDEX, 32'h0);
		bus(1'b1, ADDR_TIMES, 32'h0);
		chk(rdata, SCHED_RESET);
	endtask
	task automatic test_single();
		prog(6'h00, 32'h0204_0200, 32'h0100_3250);
		bus(1'b0, ADDR_CTRL, 32'h0);
		pressDelay <= 8'h08;
		go(1, ST_IDLE);
		chk(weldTicks, 4);
		chk(pctLast, 8'h32);
		chk(sqzSeen, 1'b1);
		chk(badPress, 0);
		chk(valvesSeen, 3'h5);
		chk(valveOn, 3'h0);
		pressDelay <= 8'h01;
	endtask
	task automatic test_pulse();
		prog(6'h03, 32'h0103_0100, 32'h0302_0A10);
		bus(1'b0, ADDR_CTRL, 32'h0300);
		go(1, ST_IDLE);
		chk(weldRises, 3);
		chk(weldTicks, 9);
	endtask
	task automatic test_chain();
		prog(6'h0B, 32'h0102_0100, 32'h0100_1412);
		prog(6'h0C, 32'h0102_0100, 32'h0100_2860);
		bus(1'b0, ADDR_CTRL, 32'h0B00);
		go(1, ST_IDLE);
		chk(valvesSeen, 3'h7);
		chk(pctLast, 8'h28);
		chk(weldRises, 2);
		chk(displaySched, 6'h0B);
		bus(1'b1, ADDR_STATUS, 32'h0);
		chk(rdata[21:16], 6'h0B);
	endtask
	task automatic test_repeat();
		prog(6'h14, 32'h0101_0102, 32'h0100_1011);
		bus(1'b0, ADDR_CTRL, 32'h1400);
		go(3, ST_IDLE);
		chk(sqzStarts, 3);
		chk(weldRises, 3);
	endtask
	task automatic test_succ();
		prog(6'h1E, 32'h0101_0100, 32'h0100_1013);
		prog(6'h1F, 32'h0101_0100, 32'h0100_1013);
		prog(6'h20, 32'h0101_0100, 32'h0100_1010);
		bus(1'b0, ADDR_CTRL, 32'h1E00);
		go(1, ST_IDLE);
		chk(displaySched, 6'h1F);
		chk(schedFlash, 1'b1);
		go(1, ST_IDLE);
		chk(displaySched, 6'h20);
		step(8);
		chk(displaySched, 6'h1F);
		go(1, ST_IDLE);
		clr();
		step(300);
		chk(displaySched, 6'h1E);
		chk(errSeen, 1'b1);
		step(8);
		chk(displaySched, 6'h1E);
		repeat (3) go(1, ST_IDLE);
		chk(displaySched, 6'h1E);
		chk(schedFlash, 1'b0);
	endtask
	// wait-here keeps its valves, then jump b runs schedule 20, jump a schedule 10
	task automatic test_jump();
		prog(6'h0A, 32'h0101_0100, 32'h0100_1040);
		prog(6'h28, 32'h0101_0100, 32'h0100_1025);
		bus(1'b0, ADDR_CTRL, 32'h2800);
		for (int k = 0; k < 2; k++) begin
			go(1, ST_JUMPWAIT);
			clr();
			@(posedge clk_sys);
			jumpA <= (k == 1);
			jumpB <= (k == 0);
			do @(negedge clk_sys); while (seqState === ST_JUMPWAIT);
			@(posedge clk_sys);
			jumpA <= 1'b0;
			jumpB <= 1'b0;
			do @(negedge clk_sys); while (seqState !== ST_IDLE);
			chk(valvesSeen, (k == 0) ? 3'h3 : 3'h6);
			chk(weldRises, 1);
		end
	endtask
	// conditional successive waits with valves on, reinitiation runs the next schedule
	task automatic test_cond();
		prog(6'h2A, 32'h0101_0100, 32'h0100_1014);
		prog(6'h2B, 32'h0101_0100, 32'h0100_1820);
		bus(1'b0, ADDR_CTRL, 32'h2A00);
		go(1, ST_CONDWAIT);
		chk(holdBlink, 1'b1);
		chk(valveOn, 3'h1);
		go(1, ST_IDLE);
		chk(valvesSeen, 3'h3);
		chk(pctLast, 8'h18);
		chk(displaySched, 6'h2A);
	endtask
	// external selection picks schedule {b,a}
	task automatic test_ext();
		selA <= 1'b1;
		selB <= 1'b1;
		bus(1'b0, ADDR_CTRL, 32'h0000_0001);
		go(1, ST_IDLE);
		chk(displaySched, 6'h03);
		chk(pctLast, 8'h0A);
		chk(weldRises, 3);
	endtask
	// watchdog against a hang
	initial begin
		repeat (60000) @(posedge clk_sys);
		fails++;
		give_verdict();
	end
	initial begin
		repeat (12) @(posedge clk_sys);
		rst_n <= 1'b1;
		test_regs();
		test_single();
		test_pulse();
		test_chain();
		test_repeat();
		test_succ();
		test_jump();
		test_cond();
		test_ext();
		give_verdict();
	end
endmodule
